// ===== core/sprc_map.vh
// constants for the trip point and relay control block
`ifndef SPRC_MAP_VH
`define SPRC_MAP_VH
// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define SPRC_OFF_CODE      4'h0
`define SPRC_OFF_TRIP      4'h1
`define SPRC_OFF_BAND      4'h2
`define SPRC_OFF_SRC       4'h3
`define SPRC_OFF_STATUS    4'h4
`define SPRC_OFF_ACTION    4'h5
// ------------------------------------------------------------
// control code field positions
// ------------------------------------------------------------
`define SPRC_CODE_D3_LSB   0
`define SPRC_CODE_D2_LSB   4
`define SPRC_CODE_D1_LSB   8
`define SPRC_CODE_DEV_BIT  12
`define SPRC_CODE_TMR_LSB  13
// ------------------------------------------------------------
// code values
// ------------------------------------------------------------
`define SPRC_D3_BAND       4'h5
`define SPRC_D2_NORMAL     4'h0
`define SPRC_D2_SRCSEL     4'h1
`define SPRC_D2_SW1        4'h5
`define SPRC_D2_SW2        4'h6
`define SPRC_D2_SWLOCK     4'h7
`define SPRC_SRC_RATE      3'h0
`define SPRC_SRC_TOT1      3'h1
`define SPRC_SRC_TOT2      3'h2
`define SPRC_SRC_PEAK      3'h3
`define SPRC_SRC_VALLEY    3'h4
`define SPRC_TIMER_MODES   3'h7
// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define SPRC_RST_CODE      16'h0000
`define SPRC_RST_TRIP      32'h00000000
`define SPRC_RST_BAND      16'h0001
`define SPRC_RST_SRC       3'h0
`endif

// ===== core/sprc_compare.v
// band comparator: raw activation level from reading and trip point
`timescale 1ns/1ps
module sprc_compare #(
   parameter W = 32
) (
   // operands
   input  wire signed [W-1:0] reading,
   input  wire signed [W-1:0] tripPoint,
   input  wire        [15:0]  band,
   // mode
   input  wire                bandMode,
   input  wire                devMode,
   input  wire                below,
   input  wire                prevActive,
   // result
   output reg                 active
);
   // widened by two bits so trip point +/- 65535 never wraps
   wire signed [W+1:0] rd = {{2{reading[W-1]}}, reading};
   wire signed [W+1:0] tp = {{2{tripPoint[W-1]}}, tripPoint};
   wire signed [W+1:0] bw = {{(W-14){1'b0}}, band};
   wire signed [W+1:0] hi = tp + bw;
   wire signed [W+1:0] lo = tp - bw;
   wire aboveHi = (rd >= hi);
   wire belowLo = (rd < lo);
   wire inBand  = (rd >= lo) && (rd <= hi);

   // combinational decision, held state only used in hysteresis
   always @* begin
      if (!bandMode) begin
         // plain trip point: above or below
         active = below ? (rd < tp) : (rd >= tp);
      end else if (devMode) begin
         active = below ? !inBand : inBand;
      end else if (!below) begin
         // between the thresholds the old state holds
         active = aboveHi ? 1'b1 : (belowLo ? 1'b0 : prevActive);
      end else begin
         active = belowLo ? 1'b1 : (aboveHi ? 1'b0 : prevActive);
      end
   end
endmodule

// ===== core/sprc_relay_control.v
// trip point comparator and relay drive with start-up inhibit
//
// Summary of operation
// - codes 0,1: first activation after power-up inhibited
// - code 2: inhibit only on falling signal
// - code 3: inhibit only on rising signal
// - inhibit: activate, deactivate, energize second time
// - hysteresis above: on at trip+h, off below trip-h
// - hysteresis below: on below trip-h, off at trip+h
// - code 2 hysteresis: like 0, falling inhibit
// - code 3 hysteresis: like 1, rising inhibit
// - deviation codes 0,2: energize inside band
// - deviation codes 1,3: energize outside band
// - deviation code 2: first energize entering band
// - deviation code 3: first energize leaving band
// - second digit 1 selects activation source
// - second digit 5,6,7 select switch trigger
// - grounded selected switch triggers and acts
// - switch trigger overrides chosen source
// - reset inputs always clear their totalizer
// - lock input: view allowed, changes rejected
// - both buttons in run display reset relay
// - seven timer modes held as a code field
// - hysteresis 0 to 65535 counts symmetric
// - deviation 1 to 65535 counts symmetric
`timescale 1ns/1ps
`include "sprc_map.vh"
module sprc_relay_control #(
   parameter W = 32
) (
   // clock and reset
   input  wire         clk,
   input  wire         nrst,
   // register port
   input  wire [3:0]   regAddr,
   input  wire [31:0]  regWdata,
   input  wire         regWr,
   input  wire         regRd,
   output reg  [31:0]  regRdata,
   // reading sources, sharing one new-value strobe
   input  wire [W-1:0] rateValue,
   input  wire [W-1:0] totOneValue,
   input  wire [W-1:0] totTwoValue,
   input  wire [W-1:0] peakValue,
   input  wire [W-1:0] valleyValue,
   input  wire         sampleValid,
   // external contact switches, low when grounded
   input  wire         totalOneClearInputN,
   input  wire         totalTwoClearInputN,
   input  wire         lockInputN,
   // front buttons, both pressed with run display shown
   input  wire         manualResetBtns,
   input  wire         runDisplay,
   // outputs
   output reg          relayOn,
   output reg          totOneClear,
   output reg          totTwoClear,
   output reg          paramLock
);
   // ------------------------------------------------------------
   // state codes for the inhibit sequence, one-hot
   // ------------------------------------------------------------
   localparam [2:0] ST_ARMED = 3'b001; // waiting for first activation
   localparam [2:0] ST_FIRST = 3'b010; // first activation seen
   localparam [2:0] ST_RUN   = 3'b100; // inhibit done, relay follows

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   reg [15:0]  codeReg;      // control digits and flags
   reg [W-1:0] tripReg;      // trip point
   reg [15:0]  bandReg;      // hysteresis or deviation counts
   reg [2:0]   srcReg;       // chosen activation source
   reg [2:0]   stateReg;     // inhibit sequence state
   reg [2:0]   stateNext;
   reg         activeReg;    // last evaluated activation level
   reg         activeNext;
   reg [W-1:0] lastRdReg;    // previous reading for slope
   reg         risingReg;    // last slope was upward
   reg         manualOffReg; // relay reset by operator
   reg         swPrevReg;    // previous selected switch level

   // control fields
   wire [3:0] digitOne   = codeReg[`SPRC_CODE_D1_LSB +: 4];
   wire [3:0] digitTwo   = codeReg[`SPRC_CODE_D2_LSB +: 4];
   wire [3:0] digitThree = codeReg[`SPRC_CODE_D3_LSB +: 4];
   wire       devSel     = codeReg[`SPRC_CODE_DEV_BIT];
   wire [2:0] timerSel   = codeReg[`SPRC_CODE_TMR_LSB +: 3];
   wire       bandMode   = (digitThree == `SPRC_D3_BAND);
   wire       belowMode  = digitOne[0];  // codes 1 and 3 energize below

   // ------------------------------------------------------------
   // source selection
   // ------------------------------------------------------------
   // pick the reading named by the source code
   function [W-1:0] pickSource;
      input [2:0] sel;
      begin
         case (sel)
            `SPRC_SRC_TOT1:   pickSource = totOneValue;
            `SPRC_SRC_TOT2:   pickSource = totTwoValue;
            `SPRC_SRC_PEAK:   pickSource = peakValue;
            `SPRC_SRC_VALLEY: pickSource = valleyValue;
            default:          pickSource = rateValue;
         endcase
      end
   endfunction

   wire [W-1:0] reading = pickSource(srcReg);

   // switch trigger: selected input grounded, overrides source
   wire swSelected = (digitTwo == `SPRC_D2_SW1) ||
                     (digitTwo == `SPRC_D2_SW2) ||
                     (digitTwo == `SPRC_D2_SWLOCK);
   reg  swLevel;
   always @* begin
      if (digitTwo == `SPRC_D2_SW1) begin
         swLevel = !totalOneClearInputN;
      end else if (digitTwo == `SPRC_D2_SW2) begin
         swLevel = !totalTwoClearInputN;
      end else if (digitTwo == `SPRC_D2_SWLOCK) begin
         swLevel = !lockInputN;
      end else begin
         swLevel = 1'b0;
      end
   end

   // ------------------------------------------------------------
   // comparator
   // ------------------------------------------------------------
   wire cmpActive;
   sprc_compare #(.W(W)) uCmp (
      .reading    (reading),
      .tripPoint  (tripReg),
      .band       (bandReg),
      .bandMode   (bandMode),
      .devMode    (devSel),
      .below      (belowMode),
      .prevActive (activeReg),
      .active     (cmpActive)
   );

   // evaluation happens on a fresh sample, or in switch mode only on a change of the selected switch
   wire swEvent  = swSelected && (swLevel != swPrevReg);
   wire evalNow  = swSelected ? swEvent : sampleValid;
   wire newLevel = swSelected ? swLevel : cmpActive;
   wire isRising = ($signed(reading) > $signed(lastRdReg)) ? 1'b1 :
                   (reading == lastRdReg) ? risingReg : 1'b0;

   // inhibit applies per code: 0/1 always, 2 falling, 3 rising
   function inhibitApplies;
      input [3:0] d1;
      input       rising;
      begin
         if (d1 == 4'h2) begin
            inhibitApplies = !rising;
         end else if (d1 == 4'h3) begin
            inhibitApplies = rising;
         end else begin
            inhibitApplies = 1'b1;
         end
      end
   endfunction

   // ------------------------------------------------------------
   // inhibit sequence
   // ------------------------------------------------------------
   // the second activation of codes 2 and 3 arrives on the
   // opposite slope, so the first activation is judged by slope
   always @* begin
      stateNext  = stateReg;
      activeNext = activeReg;
      if (evalNow) begin
         activeNext = newLevel;
         case (stateReg)
            ST_ARMED: begin
               if (newLevel && !activeReg) begin
                  if (inhibitApplies(digitOne, isRising)) begin
                     stateNext = ST_FIRST;
                  end else begin
                     stateNext = ST_RUN;
                  end
               end
            end
            ST_FIRST: begin
               // deactivation ends the inhibited cycle
               if (!newLevel) begin
                  stateNext = ST_RUN;
               end
            end
            ST_RUN: begin
               stateNext = ST_RUN;
            end
            default: begin
               stateNext = ST_ARMED;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // state, relay and slope registers
   // ------------------------------------------------------------
   always @(posedge clk) begin
      if (!nrst) begin
         stateReg     <= ST_ARMED;
         activeReg    <= 1'b0;
         lastRdReg    <= {W{1'b0}};
         risingReg    <= 1'b1;
         manualOffReg <= 1'b0;
         swPrevReg    <= 1'b0;
         relayOn      <= 1'b0;
      end else begin
         stateReg  <= stateNext;
         activeReg <= activeNext;
         swPrevReg <= swLevel;
         if (sampleValid) begin
            lastRdReg <= reading;
            risingReg <= isRising;
         end
         // operator reset drops the relay until next activation
         if (manualResetBtns && runDisplay) begin
            manualOffReg <= 1'b1;
         end else if (evalNow && newLevel && !activeReg) begin
            manualOffReg <= 1'b0;
         end
         // relay only while past the inhibit and active
         relayOn <= (stateNext == ST_RUN) && activeNext &&
                    !(manualResetBtns && runDisplay) &&
                    !(manualOffReg && !(evalNow && newLevel &&
                                        !activeReg));
      end
   end

   // ------------------------------------------------------------
   // external switch functions, always active when grounded
   // ------------------------------------------------------------
   always @(posedge clk) begin
      if (!nrst) begin
         totOneClear <= 1'b0;
         totTwoClear <= 1'b0;
         paramLock   <= 1'b0;
      end else begin
         totOneClear <= !totalOneClearInputN;
         totTwoClear <= !totalTwoClearInputN;
         paramLock   <= !lockInputN;
      end
   end

   // ------------------------------------------------------------
   // register writes, blocked while locked
   // ------------------------------------------------------------
   // a zero deviation would leave a band holding only the trip point; it is raised to 1
   always @(posedge clk) begin
      if (!nrst) begin
         codeReg <= `SPRC_RST_CODE;
         tripReg <= `SPRC_RST_TRIP;
         bandReg <= `SPRC_RST_BAND;
         srcReg  <= `SPRC_RST_SRC;
      end else if (regWr && lockInputN) begin
         if (regAddr == `SPRC_OFF_CODE) begin
            codeReg <= regWdata[15:0];
         end else if (regAddr == `SPRC_OFF_TRIP) begin
            tripReg <= regWdata[W-1:0];
         end else if (regAddr == `SPRC_OFF_BAND) begin
            // full 0..65535 accepted; deviation floor of 1
            if (devSel && regWdata[15:0] == 16'h0000) begin
               bandReg <= 16'h0001;
            end else begin
               bandReg <= regWdata[15:0];
            end
         end else if (regAddr == `SPRC_OFF_SRC) begin
            // source only taken while in selection digit
            if (digitTwo == `SPRC_D2_SRCSEL) begin
               srcReg <= regWdata[2:0];
            end
         end
      end
   end

   // ------------------------------------------------------------
   // register reads, one cycle later
   // ------------------------------------------------------------
   always @(posedge clk) begin
      if (!nrst) begin
         regRdata <= 32'h00000000;
      end else if (regRd) begin
         if (regAddr == `SPRC_OFF_CODE) begin
            regRdata <= {16'h0000, codeReg};
         end else if (regAddr == `SPRC_OFF_TRIP) begin
            regRdata <= tripReg;
         end else if (regAddr == `SPRC_OFF_BAND) begin
            regRdata <= {16'h0000, bandReg};
         end else if (regAddr == `SPRC_OFF_SRC) begin
            regRdata <= {29'h0000000, srcReg};
         end else if (regAddr == `SPRC_OFF_STATUS) begin
            regRdata <= {22'h000000, timerSel, paramLock, manualOffReg,
                         activeReg, stateReg, relayOn};
         end else begin
            // unmapped reads as zero
            regRdata <= 32'h00000000;
         end
      end else begin
         regRdata <= 32'h00000000;
      end
   end
endmodule

// ===== tb/sprc_relay_control_props.sv
// checker of the relay control port behaviour
`timescale 1ns/1ps
module sprc_props #(
   parameter W = 32
) (
   // clock, reset, register port
   input wire         clk,
   input wire         nrst,
   input wire [3:0]   regAddr,
   input wire [31:0]  regWdata,
   input wire         regWr,
   input wire         regRd,
   input wire [31:0]  regRdata,
   // reading sources and switches
   input wire [W-1:0] rateValue,
   input wire [W-1:0] totOneValue,
   input wire [W-1:0] totTwoValue,
   input wire [W-1:0] peakValue,
   input wire [W-1:0] valleyValue,
   input wire         sampleValid,
   input wire         totalOneClearInputN,
   input wire         totalTwoClearInputN,
   input wire         lockInputN,
   input wire         manualResetBtns,
   input wire         runDisplay,
   // outputs
   input wire         relayOn,
   input wire         totOneClear,
   input wire         totTwoClear,
   input wire         paramLock
);
   // -----------------------------------------
   // helpers
   // -----------------------------------------
   wire [2:0] swIn = {totalOneClearInputN, totalTwoClearInputN, lockInputN};
   wire       anySw = totOneClear | totTwoClear | paramLock; // switch copies
   wire       manPress = manualResetBtns & runDisplay;      // manual reset
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   // no cause for a relay change in this cycle
   sequence s_quiet;
      !sampleValid && !manualResetBtns && !regWr && $stable(swIn);
   endsequence
   // -----------------------------------------
   // properties
   // -----------------------------------------
   a_rd_idle: assert property (!$past(regRd) |-> regRdata == 32'h0)
      else $error("read data outside its cycle");
   a_rst_out: assert property (!$past(nrst) |->
      !relayOn && !totOneClear && !totTwoClear && !paramLock)
      else $error("outputs not cleared by reset");
   a_clr_one: assert property ($past(nrst) |->
      totOneClear == !$past(totalOneClearInputN))
      else $error("total one clear does not follow its contact");
   a_clr_two: assert property ($past(nrst) |->
      totTwoClear == !$past(totalTwoClearInputN))
      else $error("total two clear does not follow its contact");
   a_lock_copy: assert property ($past(nrst) |->
      paramLock == !$past(lockInputN))
      else $error("lock output does not follow its contact");
   a_man_off: assert property (manPress && !sampleValid |=> !relayOn)
      else $error("relay on after manual reset");
   a_relay_hold: assert property (s_quiet ##1 s_quiet |=> $stable(relayOn))
      else $error("relay changed without a new value");
   a_rise_why: assert property ($rose(relayOn) |->
      $past(sampleValid) || anySw)
      else $error("relay energized without a cause");
   a_fall_why: assert property ($fell(relayOn) |->
      $past(sampleValid) || $past(manPress) || $past(anySw) || $past(anySw, 2))
      else $error("relay dropped without a cause");
endmodule

bind sprc_relay_control sprc_props #(.W(W)) sprc_props_inst (
   .clk(clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
   .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
   .rateValue(rateValue), .totOneValue(totOneValue),
   .totTwoValue(totTwoValue), .peakValue(peakValue),
   .valleyValue(valleyValue), .sampleValid(sampleValid),
   .totalOneClearInputN(totalOneClearInputN),
   .totalTwoClearInputN(totalTwoClearInputN), .lockInputN(lockInputN),
   .manualResetBtns(manualResetBtns), .runDisplay(runDisplay),
   .relayOn(relayOn), .totOneClear(totOneClear),
   .totTwoClear(totTwoClear), .paramLock(paramLock)
);

// ===== tb/sprc_field_model.sv
// field side: reading sources and grounded contact switches
`timescale 1ns/1ps
module sprc_field_model (
   // clock
   input wire        clk,
   // reading sources
   output reg [31:0] rateValue,
   output reg [31:0] totOneValue,
   output reg [31:0] totTwoValue,
   output reg [31:0] peakValue,
   output reg [31:0] valleyValue,
   output reg        sampleValid,
   // contacts, pulled up while open
   output reg        totalOneClearInputN,
   output reg        totalTwoClearInputN,
   output reg        lockInputN
);
   // all sources at zero, all contacts open
   initial begin
      {rateValue, totOneValue, totTwoValue} = 96'h0;
      {peakValue, valleyValue} = 64'h0;
      sampleValid = 1'b0;
      {totalOneClearInputN, totalTwoClearInputN, lockInputN} = 3'h7;
   end
   // a source keeps its reading until the next one arrives
   task sample(input [2:0] sel, input [31:0] v);
      @(posedge clk);
      case (sel)
         3'h0: rateValue <= v;
         3'h1: totOneValue <= v;
         3'h2: totTwoValue <= v;
         3'h3: peakValue <= v;
         default: valleyValue <= v;
      endcase
      sampleValid <= 1'b1;
      @(posedge clk);
      sampleValid <= 1'b0;
   endtask
   // an open contact reads high through its pull-up
   task sw(input [1:0] idx, input closed);
      @(posedge clk);
      case (idx)
         2'h0: totalOneClearInputN <= !closed;
         2'h1: totalTwoClearInputN <= !closed;
         default: lockInputN <= !closed;
      endcase
   endtask
endmodule

// ===== tb/sprc_relay_control_tb.sv
// self-checking bench of the trip point relay control
`timescale 1ns/1ps
`include "sprc_map.vh"
module sprc_relay_control_tb;
   // -----------------------------------------
   // signals
   // -----------------------------------------
   reg         clk, nrst, regWr, regRd, manualResetBtns, runDisplay;
   reg  [3:0]  regAddr;
   reg  [31:0] regWdata;
   wire [31:0] regRdata, rateValue, totOneValue, totTwoValue;
   wire [31:0] peakValue, valleyValue;
   wire        sampleValid, n1, n2, nl;
   wire        relayOn, totOneClear, totTwoClear, paramLock;
   integer     num_errors, checks_done;
   sprc_relay_control #(.W(32)) sprc_relay_control_inst (
      .clk(clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .rateValue(rateValue), .totOneValue(totOneValue),
      .totTwoValue(totTwoValue), .peakValue(peakValue),
      .valleyValue(valleyValue), .sampleValid(sampleValid),
      .totalOneClearInputN(n1), .totalTwoClearInputN(n2),
      .lockInputN(nl), .manualResetBtns(manualResetBtns),
      .runDisplay(runDisplay), .relayOn(relayOn),
      .totOneClear(totOneClear), .totTwoClear(totTwoClear),
      .paramLock(paramLock));
   sprc_field_model sprc_field_model_inst (
      .clk(clk), .rateValue(rateValue), .totOneValue(totOneValue),
      .totTwoValue(totTwoValue), .peakValue(peakValue),
      .valleyValue(valleyValue), .sampleValid(sampleValid),
      .totalOneClearInputN(n1), .totalTwoClearInputN(n2), .lockInputN(nl));
   // 125 MHz clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // -----------------------------------------
   // shared tasks
   // -----------------------------------------
   task chk(input [31:0] seen, input [31:0] exp, input string nm);
      checks_done = checks_done + 1;
      if (seen !== exp) begin
         num_errors = num_errors + 1;
         $display("[FAIL] %0s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task print_verdict;
      if (num_errors == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task rst;
      @(posedge clk);
      nrst <= 1'b0;
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
   endtask
   task wr(input [3:0] a, input [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   // read data is looked at in the one cycle where it stands
   task rdc(input [3:0] a, input [31:0] e, input string nm);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 chk(regRdata, e, nm);
   endtask
   // one new reading, relay judged once it has settled
   task smp(input [2:0] s, input [31:0] v, input e);
      sprc_field_model_inst.sample(s, v);
      @(posedge clk);
      #1 chk({31'h0, relayOn}, {31'h0, e}, "relayOn");
   endtask
   task settle;
      repeat (3) @(posedge clk);
      #1;
   endtask
   // -----------------------------------------
   // scenarios
   // -----------------------------------------
   task t_regs;
      rst;
      rdc(`SPRC_OFF_CODE, {16'h0, `SPRC_RST_CODE}, "code");
      rdc(`SPRC_OFF_TRIP, `SPRC_RST_TRIP, "trip");
      rdc(`SPRC_OFF_BAND, {16'h0, `SPRC_RST_BAND}, "band");
      rdc(`SPRC_OFF_SRC, {29'h0, `SPRC_RST_SRC}, "source");
      rdc(4'hf, 32'h0, "unmapped");
      wr(`SPRC_OFF_CODE, 32'he000);
      rdc(`SPRC_OFF_CODE, 32'he000, "timer code");
   endtask
   // plain compare, band ignored without third digit 5
   task t_above;
      rst;
      wr(`SPRC_OFF_TRIP, 32'h64);
      wr(`SPRC_OFF_BAND, 32'h32);
      smp(3'h0, 32'h96, 1'b0);
      smp(3'h0, 32'h32, 1'b0);
      smp(3'h0, 32'h64, 1'b1);
      smp(3'h0, 32'h63, 1'b0);
      smp(3'h0, 32'h78, 1'b1);
      rdc(`SPRC_OFF_STATUS, 32'h19, "status run");
      @(posedge clk);
      manualResetBtns <= 1'b1;
      @(posedge clk);
      runDisplay <= 1'b1;
      manualResetBtns <= 1'b0;
      settle;
      chk({31'h0, relayOn}, 32'h1, "no display");
      manualResetBtns <= 1'b1;
      @(posedge clk);
      manualResetBtns <= 1'b0;
      settle;
      chk({31'h0, relayOn}, 32'h0, "manual off");
      runDisplay <= 1'b0;
   endtask
   task t_hyst;
      rst;
      wr(`SPRC_OFF_CODE, 32'h5);
      wr(`SPRC_OFF_TRIP, 32'h1f4);
      wr(`SPRC_OFF_BAND, 32'ha);
      smp(3'h0, 32'h1fe, 1'b0);
      smp(3'h0, 32'h1e0, 1'b0);
      smp(3'h0, 32'h1fd, 1'b0);
      smp(3'h0, 32'h1fe, 1'b1);
      smp(3'h0, 32'h1ea, 1'b1);
      smp(3'h0, 32'h1e9, 1'b0);
      rst;
      wr(`SPRC_OFF_CODE, 32'h105);
      wr(`SPRC_OFF_TRIP, 32'h1f4);
      wr(`SPRC_OFF_BAND, 32'ha);
      smp(3'h0, 32'h1e0, 1'b0);
      smp(3'h0, 32'h208, 1'b0);
      smp(3'h0, 32'h1e9, 1'b1);
      smp(3'h0, 32'h1fd, 1'b1);
      smp(3'h0, 32'h1fe, 1'b0);
   endtask
   task t_dev;
      rst;
      wr(`SPRC_OFF_CODE, 32'h1005);
      wr(`SPRC_OFF_TRIP, 32'h3e8);
      wr(`SPRC_OFF_BAND, 32'h23);
      smp(3'h0, 32'h3e8, 1'b0);
      smp(3'h0, 32'h7d0, 1'b0);
      smp(3'h0, 32'h3d4, 1'b1);
      smp(3'h0, 32'h410, 1'b0);
      rst;
      wr(`SPRC_OFF_CODE, 32'h1105);
      wr(`SPRC_OFF_TRIP, 32'h3e8);
      wr(`SPRC_OFF_BAND, 32'h23);
      smp(3'h0, 32'h7d0, 1'b0);
      smp(3'h0, 32'h3e8, 1'b0);
      smp(3'h0, 32'h384, 1'b1);
      smp(3'h0, 32'h3f2, 1'b0);
   endtask
   // inhibit depends on the slope of the reading
   task t_slope;
      rst;
      wr(`SPRC_OFF_CODE, 32'h200);
      wr(`SPRC_OFF_TRIP, 32'h64);
      smp(3'h0, 32'h32, 1'b0);
      smp(3'h0, 32'h96, 1'b1);
      rst;
      wr(`SPRC_OFF_CODE, 32'h200);
      wr(`SPRC_OFF_TRIP, 32'h3e8);
      smp(3'h0, 32'h384, 1'b0);
      smp(3'h0, 32'h3b6, 1'b0);
      wr(`SPRC_OFF_TRIP, 32'h64);
      smp(3'h0, 32'h320, 1'b0);
      smp(3'h0, 32'h32, 1'b0);
      smp(3'h0, 32'hc8, 1'b1);
      rst;
      wr(`SPRC_OFF_CODE, 32'h300);
      wr(`SPRC_OFF_TRIP, 32'h64);
      smp(3'h0, 32'h96, 1'b0);
      smp(3'h0, 32'ha0, 1'b0);
      smp(3'h0, 32'h32, 1'b1);
   endtask
   task t_source;
      rst;
      wr(`SPRC_OFF_CODE, 32'h10);
      wr(`SPRC_OFF_SRC, 32'h1);
      wr(`SPRC_OFF_CODE, 32'h0);
      wr(`SPRC_OFF_TRIP, 32'h64);
      smp(3'h0, 32'h1f4, 1'b0);
      smp(3'h1, 32'hc8, 1'b0);
      smp(3'h1, 32'h0, 1'b0);
      smp(3'h1, 32'hc8, 1'b1);
      wr(`SPRC_OFF_SRC, 32'h4);
      rdc(`SPRC_OFF_SRC, 32'h1, "source kept");
   endtask
   task t_switch;
      rst;
      wr(`SPRC_OFF_CODE, 32'h50);
      wr(`SPRC_OFF_TRIP, 32'h64);
      smp(3'h0, 32'h1f4, 1'b0);
      sprc_field_model_inst.sw(2'h0, 1'b1);
      settle;
      chk({31'h0, totOneClear}, 32'h1, "clear one");
      chk({31'h0, relayOn}, 32'h0, "first trigger");
      sprc_field_model_inst.sw(2'h0, 1'b0);
      settle;
      sprc_field_model_inst.sw(2'h0, 1'b1);
      settle;
      chk({31'h0, relayOn}, 32'h1, "switch trigger");
      sprc_field_model_inst.sw(2'h0, 1'b0);
      sprc_field_model_inst.sw(2'h1, 1'b1);
      settle;
      chk({31'h0, totTwoClear}, 32'h1, "clear two");
      sprc_field_model_inst.sw(2'h1, 1'b0);
   endtask
   task t_lock;
      rst;
      sprc_field_model_inst.sw(2'h2, 1'b1);
      settle;
      chk({31'h0, paramLock}, 32'h1, "lock");
      wr(`SPRC_OFF_TRIP, 32'h4d);
      rdc(`SPRC_OFF_TRIP, 32'h0, "locked trip");
      sprc_field_model_inst.sw(2'h2, 1'b0);
      settle;
      wr(`SPRC_OFF_TRIP, 32'h4d);
      rdc(`SPRC_OFF_TRIP, 32'h4d, "free trip");
   endtask
   // -----------------------------------------
   // main sequence and hang guard
   // -----------------------------------------
   initial begin
      {nrst, regWr, regRd, manualResetBtns, runDisplay} = 5'h0;
      regAddr = 4'h0;
      regWdata = 32'h0;
      num_errors = 0;
      checks_done = 0;
      t_regs;
      t_above;
      t_hyst;
      t_dev;
      t_slope;
      t_source;
      t_switch;
      t_lock;
      print_verdict;
   end
   initial begin
      repeat (20000) @(posedge clk);
      num_errors = num_errors + 1;
      print_verdict;
   end
endmodule
